/* File: logic/clk_ctrl_pkg.sv */
// Package: constants and types for the clock source select and start-up block
package clk_ctrl_pkg;

    // ************************************************************
    // Clock mode encoding of the configuration field
    // ************************************************************
    localparam logic [2:0] MODE_EXT_CLOCK     = 3'h0;
    localparam logic [2:0] MODE_LOW_GAIN_XTAL = 3'h1;
    localparam logic [2:0] MODE_MID_GAIN_XTAL = 3'h2;
    localparam logic [2:0] MODE_HIGH_GAIN_XTAL = 3'h3;
    localparam logic [2:0] MODE_RC_CLKOUT     = 3'h4;
    localparam logic [2:0] MODE_RC_IO         = 3'h5;
    localparam logic [2:0] MODE_INT_CLKOUT    = 3'h6;
    localparam logic [2:0] MODE_INT_IO        = 3'h7;

    // ************************************************************
    // Register map (word offsets as byte addresses)
    // ************************************************************
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS  = 4'h4;
    localparam logic [3:0] ADDR_CONFIG  = 4'h8;

    // Control field positions
    localparam int CTL_SYS_CLOCK_SELECT = 0;
    localparam int CTL_FREQ_LSB         = 4;
    localparam int CTL_FREQ_MSB         = 6;
    // Status field positions
    localparam int STS_OSC_FAIL         = 0;
    localparam int STS_FAST_OSC_ON      = 1;
    localparam int STS_RUN_EXTERNAL     = 2;
    localparam int STS_CORE_HOLD        = 3;
    localparam int STS_STARTUP_DONE     = 4;

    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [2:0]  FREQ_SEL_OFF  = 3'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ            = 40;
    localparam int XTAL_PERIODS       = 1024;
    localparam int CPU_STARTUP_NS     = 10000;
    localparam int FAST_SWITCH_NS     = 1000;
    localparam int CPU_STARTUP_CYCLES = (CPU_STARTUP_NS * CLK_MHZ) / 1000;
    localparam int FAST_SWITCH_CYCLES = (FAST_SWITCH_NS * CLK_MHZ) / 1000;
    // Slow internal oscillator near 31 kHz: 40 MHz / 1290
    localparam int SLOW_OSC_DIV       = 1290;
    // Fast internal oscillator 8 MHz: 40 MHz / 5
    localparam int FAST_OSC_DIV       = 5;
    // Failure window in slow oscillator ticks
    localparam int FAIL_WINDOW_TICKS  = 2;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic bit4Out;
        logic bit4OutEn;
        logic bit4IsGpio;
        logic bit5IsGpio;
        logic clockInIsGpio;
    } pin_use_t;

    typedef struct packed {
        logic extSource;
        logic crystal;
        logic internal;
        logic clkout;
    } mode_class_t;

endpackage

/* File: logic/clock_source_select.sv */
// Clock source selection, start-up timers and fail-safe monitor
`timescale 1ns/10ps

module clock_source_select #(
    parameter int XTAL_WAIT   = clk_ctrl_pkg::XTAL_PERIODS,
    parameter int FAIL_WINDOW = clk_ctrl_pkg::FAIL_WINDOW_TICKS,
    parameter int SLOW_DIV    = clk_ctrl_pkg::SLOW_OSC_DIV
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [2:0]  clockModeConfig,
    input  wire logic        twoSpeedStartupEnable,
    input  wire logic        powerupTimerEnable,
    input  wire logic        powerupTimerDone,
    input  wire logic        wakeFromSleep,
    input  wire logic        clockInPin,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             sysClockEn,
    output logic             sysClockExternal,
    output logic             coreHold,
    output logic             fastOscEnable,
    output logic             oscFailFlag,
    output logic             porta4Out,
    output logic             porta4OutEn,
    output logic             porta4Gpio,
    output logic             porta5Gpio,
    output logic             clockInGpio
);

    // ************************************************************
    // Configuration capture and mode decode
    // ************************************************************
    logic        cfgCaptured_q;
    logic [2:0]  mode_q;
    clk_ctrl_pkg::mode_class_t modeClass;
    clk_ctrl_pkg::pin_use_t    pinUse;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfgCaptured_q <= 1'b0;
            mode_q        <= clk_ctrl_pkg::MODE_EXT_CLOCK;
        end
        else if (!cfgCaptured_q)
        begin
            cfgCaptured_q <= 1'b1;
            mode_q        <= clockModeConfig;
        end
    end

    always_comb
    begin
        modeClass = '0;
        case (mode_q)
            clk_ctrl_pkg::MODE_EXT_CLOCK:
                modeClass.extSource = 1'b1;
            clk_ctrl_pkg::MODE_LOW_GAIN_XTAL,
            clk_ctrl_pkg::MODE_MID_GAIN_XTAL,
            clk_ctrl_pkg::MODE_HIGH_GAIN_XTAL:
            begin
                modeClass.extSource = 1'b1;
                modeClass.crystal   = 1'b1;
            end
            clk_ctrl_pkg::MODE_RC_CLKOUT:
            begin
                modeClass.extSource = 1'b1;
                modeClass.clkout    = 1'b1;
            end
            clk_ctrl_pkg::MODE_RC_IO:
                modeClass.extSource = 1'b1;
            clk_ctrl_pkg::MODE_INT_CLKOUT:
            begin
                modeClass.internal = 1'b1;
                modeClass.clkout   = 1'b1;
            end
            clk_ctrl_pkg::MODE_INT_IO:
                modeClass.internal = 1'b1;
            default:
                modeClass = '0;
        endcase
    end

    // ************************************************************
    // Register bus slave
    // ************************************************************
    logic        sysClockSelect_q;
    logic [2:0]  freqSelect_q;
    logic        oscFail_q;
    logic        wrControl;
    logic        clrFail;
    logic        rdPend_q;

    assign waitrequest = read && !rdPend_q;
    assign wrControl   = write && (address == clk_ctrl_pkg::ADDR_CONTROL)
                         && byteenable[0];
    assign clrFail     = write && (address == clk_ctrl_pkg::ADDR_STATUS)
                         && byteenable[0]
                         && writedata[clk_ctrl_pkg::STS_OSC_FAIL];

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sysClockSelect_q <= clk_ctrl_pkg::CONTROL_RESET[0];
            freqSelect_q     <= clk_ctrl_pkg::FREQ_SEL_OFF;
        end
        else if (wrControl)
        begin
            sysClockSelect_q <= writedata[clk_ctrl_pkg::CTL_SYS_CLOCK_SELECT];
            freqSelect_q     <= writedata[clk_ctrl_pkg::CTL_FREQ_MSB:
                                          clk_ctrl_pkg::CTL_FREQ_LSB];
        end
    end

    // ************************************************************
    // Internal oscillator ticks
    // ************************************************************
    logic [10:0] slowCnt_q;
    logic        slowTick;
    logic [2:0]  fastCnt_q;
    logic        fastTick;

    assign slowTick = (slowCnt_q == 11'(SLOW_DIV - 1));
    assign fastTick = (fastCnt_q == 3'(clk_ctrl_pkg::FAST_OSC_DIV - 1));

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            slowCnt_q <= '0;
        else if (slowTick)
            slowCnt_q <= '0;
        else
            slowCnt_q <= slowCnt_q + 11'h001;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            fastCnt_q <= '0;
        else if (!fastOscEnable || fastTick)
            fastCnt_q <= '0;
        else
            fastCnt_q <= fastCnt_q + 3'h1;
    end

    // ************************************************************
    // Clock input edge detect
    // ************************************************************
    logic clkInPrev_q;
    logic clkInRise;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            clkInPrev_q <= 1'b0;
        else
            clkInPrev_q <= clockInPin;
    end
    assign clkInRise = clockInPin && !clkInPrev_q;

    // ************************************************************
    // Start-up sequencer
    // ************************************************************
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_XTAL,
        ST_CPU_START,
        ST_RUN
    } startup_t;

    startup_t    state_q;
    logic [10:0] xtalCnt_q;
    logic [8:0]  cpuCnt_q;
    logic        startTrigger;
    logic        xtalDone;

    // Trigger after power-up timer, or at once if it is not used
    assign startTrigger = cfgCaptured_q
                          && (!powerupTimerEnable || powerupTimerDone);
    assign xtalDone = (xtalCnt_q == 11'(XTAL_WAIT));

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            state_q <= ST_POWERUP;
        else if (wakeFromSleep)
            state_q <= modeClass.crystal ? ST_XTAL : ST_CPU_START;
        else
        begin
            case (state_q)
                ST_POWERUP:
                    if (startTrigger)
                        state_q <= modeClass.crystal ? ST_XTAL
                                                     : ST_CPU_START;
                ST_XTAL:
                    if (xtalDone)
                        state_q <= ST_RUN;
                ST_CPU_START:
                    if (cpuCnt_q == 9'(clk_ctrl_pkg::CPU_STARTUP_CYCLES))
                        state_q <= ST_RUN;
                ST_RUN:
                    state_q <= ST_RUN;
                default:
                    state_q <= ST_POWERUP;
            endcase
        end
    end

    // Counts clock input periods; stalls while the pin stops
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            xtalCnt_q <= '0;
        else if (state_q != ST_XTAL || wakeFromSleep)
            xtalCnt_q <= '0;
        else if (clkInRise && !xtalDone)
            xtalCnt_q <= xtalCnt_q + 11'h001;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            cpuCnt_q <= '0;
        else if (state_q != ST_CPU_START || wakeFromSleep)
            cpuCnt_q <= '0;
        else
            cpuCnt_q <= cpuCnt_q + 9'h001;
    end

    // ************************************************************
    // Clock source selection and fail-safe
    // ************************************************************
    logic       useInternal;
    logic       twoSpeedActive;
    logic [5:0] switchCnt_q;
    logic       fastReady_q;
    logic [3:0] failTicks_q;
    logic       failDetect;
    logic       sawEdge_q;

    assign twoSpeedActive = twoSpeedStartupEnable && (state_q == ST_XTAL);
    assign useInternal = modeClass.internal || sysClockSelect_q
                         || oscFail_q || twoSpeedActive;

    assign fastOscEnable = (freqSelect_q != clk_ctrl_pkg::FREQ_SEL_OFF)
                           && (useInternal
                               || twoSpeedStartupEnable);

    // Fast oscillator settling before it drives the system clock
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            switchCnt_q <= '0;
            fastReady_q <= 1'b0;
        end
        else if (!fastOscEnable)
        begin
            switchCnt_q <= '0;
            fastReady_q <= 1'b0;
        end
        else if (switchCnt_q == 6'(clk_ctrl_pkg::FAST_SWITCH_CYCLES))
            fastReady_q <= 1'b1;
        else
            switchCnt_q <= switchCnt_q + 6'h01;
    end

    // Watchdog on clock input edges over slow-oscillator ticks
    assign failDetect = modeClass.extSource && (state_q == ST_RUN)
                        && slowTick && !sawEdge_q
                        && (failTicks_q == 4'(FAIL_WINDOW - 1));

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sawEdge_q   <= 1'b0;
            failTicks_q <= '0;
        end
        else if (clkInRise)
        begin
            sawEdge_q   <= 1'b1;
            failTicks_q <= '0;
        end
        else if (slowTick)
        begin
            sawEdge_q   <= 1'b0;
            failTicks_q <= sawEdge_q ? 4'h0
                         : (failTicks_q == 4'(FAIL_WINDOW - 1)) ? failTicks_q
                         : failTicks_q + 4'h1;
        end
    end

    // Set wins over software clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            oscFail_q <= 1'b0;
        else if (failDetect)
            oscFail_q <= 1'b1;
        else if (clrFail)
            oscFail_q <= 1'b0;
    end
    assign oscFailFlag = oscFail_q;

    // ************************************************************
    // System clock enable and core hold
    // ************************************************************
    logic fosc;
    logic [1:0] div4Cnt_q;
    logic porta4Out_q;

    always_comb
    begin
        if (!useInternal)
            fosc = clkInRise;
        else if (fastOscEnable && fastReady_q)
            fosc = fastTick;
        else
            fosc = slowTick;
    end

    assign sysClockExternal = !useInternal;
    assign coreHold = (state_q != ST_RUN) && !twoSpeedActive;
    assign sysClockEn = fosc && !coreHold;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            div4Cnt_q   <= '0;
            porta4Out_q <= 1'b0;
        end
        else if (fosc)
        begin
            div4Cnt_q <= div4Cnt_q + 2'h1;
            if (div4Cnt_q[0])
                porta4Out_q <= !porta4Out_q;
        end
    end

    // ************************************************************
    // Pin usage
    // ************************************************************
    always_comb
    begin
        pinUse = '0;
        pinUse.bit4Out   = porta4Out_q;
        pinUse.bit4OutEn = modeClass.clkout;
        case (mode_q)
            clk_ctrl_pkg::MODE_EXT_CLOCK,
            clk_ctrl_pkg::MODE_RC_IO:
                pinUse.bit4IsGpio = 1'b1;
            clk_ctrl_pkg::MODE_INT_CLKOUT:
            begin
                pinUse.bit5IsGpio    = 1'b1;
                pinUse.clockInIsGpio = 1'b1;
            end
            clk_ctrl_pkg::MODE_INT_IO:
            begin
                pinUse.bit4IsGpio    = 1'b1;
                pinUse.bit5IsGpio    = 1'b1;
                pinUse.clockInIsGpio = 1'b1;
            end
            default:
                pinUse.bit4IsGpio = 1'b0;
        endcase
    end

    assign porta4Out   = pinUse.bit4Out;
    assign porta4OutEn = pinUse.bit4OutEn;
    assign porta4Gpio  = pinUse.bit4IsGpio;
    assign porta5Gpio  = pinUse.bit5IsGpio;
    assign clockInGpio = pinUse.clockInIsGpio;

    // ************************************************************
    // Read data
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdPend_q <= 1'b0;
        else
            rdPend_q <= read && !rdPend_q;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            readdata <= '0;
        else if (read && !rdPend_q)
        begin
            readdata <= '0;
            case (address)
                clk_ctrl_pkg::ADDR_CONTROL:
                begin
                    readdata[clk_ctrl_pkg::CTL_SYS_CLOCK_SELECT]
                        <= sysClockSelect_q;
                    readdata[clk_ctrl_pkg::CTL_FREQ_MSB:
                             clk_ctrl_pkg::CTL_FREQ_LSB] <= freqSelect_q;
                end
                clk_ctrl_pkg::ADDR_STATUS:
                begin
                    readdata[clk_ctrl_pkg::STS_OSC_FAIL]     <= oscFail_q;
                    readdata[clk_ctrl_pkg::STS_FAST_OSC_ON]  <= fastReady_q;
                    readdata[clk_ctrl_pkg::STS_RUN_EXTERNAL] <= !useInternal;
                    readdata[clk_ctrl_pkg::STS_CORE_HOLD]    <= coreHold;
                    readdata[clk_ctrl_pkg::STS_STARTUP_DONE]
                        <= (state_q == ST_RUN);
                end
                clk_ctrl_pkg::ADDR_CONFIG:
                    readdata[2:0] <= mode_q;
                default:
                    readdata <= '0;
            endcase
        end
    end

endmodule

/* File: dv/clock_source_select_chk.sv */
// Checker: port properties of the clock source select block
`timescale 1ns/10ps
module clock_source_select_chk #(
    parameter int XTAL_WAIT = 8
) (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [2:0]  clockModeConfig,
    input wire logic        twoSpeedStartupEnable,
    input wire logic        wakeFromSleep,
    input wire logic        clockInPin,
    input wire logic [3:0]  address,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic        sysClockEn,
    input wire logic        sysClockExternal,
    input wire logic        coreHold,
    input wire logic        oscFailFlag,
    input wire logic        porta4OutEn,
    input wire logic        porta4Gpio,
    input wire logic        porta5Gpio
);
    logic       gotQ;
    logic       pinQ;
    logic [2:0] modeQ;
    int         riseQ;
    int         holdQ;
    wire        xtal = gotQ && modeQ >= 3'h1 && modeQ <= 3'h3;
    wire        clr  = write && byteenable[0] && writedata[0]
                       && address == clk_ctrl_pkg::ADDR_STATUS;

    // Mode copy and start-up counters
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            gotQ  <= 1'b0;
            modeQ <= 3'h0;
            pinQ  <= 1'b0;
            riseQ <= 0;
            holdQ <= 0;
        end
        else
        begin
            gotQ <= 1'b1;
            pinQ <= clockInPin;
            if (!gotQ)
                modeQ <= clockModeConfig;
            riseQ <= (!coreHold || wakeFromSleep) ? 0
                     : riseQ + int'(clockInPin && !pinQ);
            holdQ <= (!coreHold || wakeFromSleep) ? 0 : holdQ + 1;
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_ext_pins: assert property (gotQ && modeQ == 3'h0
        |-> porta4Gpio && !porta4OutEn) else $error("ext pin use");
    chk_rc_clkout: assert property (gotQ && modeQ == 3'h4
        |-> porta4OutEn && !porta4Gpio) else $error("rc clkout pin");
    chk_rc_io_pins: assert property (gotQ && modeQ == 3'h5
        |-> porta4Gpio && !porta4OutEn) else $error("rc io pin");
    chk_int_clkout: assert property (gotQ && modeQ == 3'h6
        |-> porta4OutEn && porta5Gpio) else $error("int clkout pins");
    chk_int_io: assert property (gotQ && modeQ == 3'h7
        |-> porta4Gpio && porta5Gpio && !porta4OutEn)
        else $error("int io pins");
    chk_hold_stops: assert property (coreHold |-> !sysClockEn)
        else $error("clock enable while held");
    chk_xtal_count: assert property (xtal && !twoSpeedStartupEnable
        && $fell(coreHold) |-> riseQ >= XTAL_WAIT - 1)
        else $error("start-up ended early");
    chk_cpu_delay: assert property (gotQ && !xtal
        |-> holdQ <= clk_ctrl_pkg::CPU_STARTUP_CYCLES + 4)
        else $error("start-up delay too long");
    chk_flag_sticky: assert property (oscFailFlag && !clr
        |=> oscFailFlag) else $error("fail flag dropped");
    chk_fail_switch: assert property ($rose(oscFailFlag)
        |-> ##[0:2] !sysClockExternal) else $error("no fallback");
endmodule

bind clock_source_select clock_source_select_chk #(
    .XTAL_WAIT(XTAL_WAIT)) chkInst (
    .mclk(mclk), .rstn(rstn), .clockModeConfig(clockModeConfig),
    .twoSpeedStartupEnable(twoSpeedStartupEnable),
    .wakeFromSleep(wakeFromSleep), .clockInPin(clockInPin),
    .address(address), .write(write), .writedata(writedata),
    .byteenable(byteenable), .sysClockEn(sysClockEn),
    .sysClockExternal(sysClockExternal), .coreHold(coreHold),
    .oscFailFlag(oscFailFlag), .porta4OutEn(porta4OutEn),
    .porta4Gpio(porta4Gpio), .porta5Gpio(porta5Gpio));

/* File: dv/clock_source_model.sv */
// Model: external clock source feeding the clock input pin
`timescale 1ns/10ps
module clock_source_model (
    input  wire logic       mclk,
    input  wire logic       running,
    input  wire logic [7:0] halfPeriod,
    output logic            clockInPin = 1'b0
);
    logic [7:0] countQ = 8'h00;

    // Logic-level clock; a stopped source parks the pin
    always @(posedge mclk)
    begin
        if (!running)
            countQ <= 8'h00;
        else if (countQ + 8'h01 >= halfPeriod)
        begin
            countQ     <= 8'h00;
            clockInPin <= ~clockInPin;
        end
        else
            countQ <= countQ + 8'h01;
    end
endmodule

/* File: dv/clock_source_select_bench.sv */
// Bench: self-checking test of the clock source select block
`timescale 1ns/10ps
module clock_source_select_bench;
    localparam int XW = 8;
    localparam int HALF = 40;
    localparam int XCYC = 2 * XW * HALF;
    localparam int CPU = clk_ctrl_pkg::CPU_STARTUP_CYCLES;
    localparam logic [7:0] P4GPIO = 8'hA1;
    localparam logic [7:0] P4OUT = 8'h50;
    localparam logic [7:0] P5GPIO = 8'hC0;
    localparam logic [7:0] EXTSYS = 8'h3F;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  modeCfg = 3'h0;
    logic        twoSpeed = 1'b0;
    logic        pwrEn = 1'b0;
    logic        pwrDone = 1'b0;
    logic        wake = 1'b0;
    logic        srcRun = 1'b1;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic [31:0] rdVal;
    logic        waitrequest, sysClockEn, sysClockExternal, coreHold;
    logic        fastOscEnable, oscFailFlag, porta4Out, porta4OutEn;
    logic        porta4Gpio, porta5Gpio, clockInGpio, clockInPin;
    int          errors = 0;
    int          totalChecks = 0;
    int          held;

    always #12.5 mclk = ~mclk;

    clock_source_model src (.mclk(mclk), .running(srcRun),
        .halfPeriod(8'h28), .clockInPin(clockInPin));

    clock_source_select #(.XTAL_WAIT(XW), .SLOW_DIV(64)) dut (
        .mclk(mclk), .rstn(rstn), .clockModeConfig(modeCfg),
        .twoSpeedStartupEnable(twoSpeed), .powerupTimerEnable(pwrEn),
        .powerupTimerDone(pwrDone), .wakeFromSleep(wake),
        .clockInPin(clockInPin), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF),
        .readdata(readdata), .waitrequest(waitrequest),
        .sysClockEn(sysClockEn), .sysClockExternal(sysClockExternal),
        .coreHold(coreHold), .fastOscEnable(fastOscEnable),
        .oscFailFlag(oscFailFlag), .porta4Out(porta4Out),
        .porta4OutEn(porta4OutEn), .porta4Gpio(porta4Gpio),
        .porta5Gpio(porta5Gpio), .clockInGpio(clockInGpio));

    task automatic summarize;
        $display("checks %0d mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic busAccess(input logic isWrite, input logic [3:0] addr,
                             input logic [31:0] data);
        int n = 0;
        address <= addr;
        writedata <= data;
        write <= isWrite;
        read <= ~isWrite;
        do
        begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rdVal = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 50)
        begin
            errors++;
            summarize();
        end
        @(posedge mclk);
    endtask

    task automatic waitRun;
        held = 0;
        while (coreHold !== 1'b0 && held < 3000)
        begin
            @(posedge mclk);
            held++;
        end
        if (held >= 3000)
        begin
            errors++;
            summarize();
        end
    endtask

    task automatic startUp(input logic [2:0] mode);
        rstn <= 1'b0;
        modeCfg <= mode;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        waitRun();
    endtask

    task automatic testModes;
        int pulses;
        int rises;
        logic last;
        for (int m = 0; m < 8; m++)
        begin
            startUp(3'(m));
            if (m >= 1 && m <= 3)
                check("xtal", 1, 32'(held >= XCYC - 2 * HALF));
            else
                check("cpu", 1, 32'(held >= CPU - 4 && held <= CPU + 4));
            check("p4 gpio", 32'(P4GPIO[m]), 32'(porta4Gpio));
            check("p4 out", 32'(P4OUT[m]), 32'(porta4OutEn));
            check("p5 gpio", 32'(P5GPIO[m]), 32'(porta5Gpio));
            check("clkin gpio", 32'(P5GPIO[m]), 32'(clockInGpio));
            check("ext sys", 32'(EXTSYS[m]), 32'(sysClockExternal));
            busAccess(1'b0, clk_ctrl_pkg::ADDR_CONFIG, 32'h0);
            check("config", 32'(m), rdVal);
            if (m == 4 || m == 6)
            begin
                pulses = 0;
                rises = 0;
                last = porta4Out;
                repeat (1600)
                begin
                    @(posedge mclk);
                    pulses += int'(sysClockEn);
                    rises += int'(porta4Out && !last);
                    last = porta4Out;
                end
                check("div4", 1, 32'(rises > 0 && rises * 4 >= pulses - 8
                      && rises * 4 <= pulses + 8));
            end
        end
        modeCfg <= 3'h1;
        busAccess(1'b1, clk_ctrl_pkg::ADDR_CONFIG, 32'h3);
        busAccess(1'b0, clk_ctrl_pkg::ADDR_CONFIG, 32'h0);
        check("locked", 32'h7, rdVal);
        check("p5 kept", 1, 32'(porta5Gpio));
        busAccess(1'b0, 4'hC, 32'h0);
        check("unmapped", 32'h0, rdVal);
        $display("test modes done");
    endtask

    task automatic testSelectFail;
        int n = 0;
        startUp(3'h0);
        busAccess(1'b1, clk_ctrl_pkg::ADDR_CONTROL, 32'h71);
        repeat (45) @(posedge mclk);
        check("int sys", 0, 32'(sysClockExternal));
        check("fast on", 1, 32'(fastOscEnable));
        busAccess(1'b0, clk_ctrl_pkg::ADDR_STATUS, 32'h0);
        check("fast ready", 1, 32'(rdVal[1]));
        busAccess(1'b1, clk_ctrl_pkg::ADDR_CONTROL, 32'h01);
        check("fast off", 0, 32'(fastOscEnable));
        busAccess(1'b1, clk_ctrl_pkg::ADDR_CONTROL, 32'h00);
        repeat (45) @(posedge mclk);
        check("ext back", 1, 32'(sysClockExternal));
        srcRun <= 1'b0;
        while (oscFailFlag !== 1'b1 && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        check("fail flag", 1, 32'(oscFailFlag));
        check("fallback", 0, 32'(sysClockExternal));
        srcRun <= 1'b1;
        repeat (200) @(posedge mclk);
        check("sticky", 1, 32'(oscFailFlag));
        busAccess(1'b1, clk_ctrl_pkg::ADDR_STATUS, 32'h1);
        busAccess(1'b0, clk_ctrl_pkg::ADDR_STATUS, 32'h0);
        check("cleared", 0, 32'(rdVal[0]));
        $display("test select and fail done");
    endtask

    task automatic testStartSeq;
        twoSpeed <= 1'b1;
        startUp(3'h2);
        check("two speed", 1, 32'(held < XCYC - 2 * HALF));
        busAccess(1'b1, clk_ctrl_pkg::ADDR_CONTROL, 32'h70);
        check("fast two", 1, 32'(fastOscEnable));
        twoSpeed <= 1'b0;
        startUp(3'h1);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        @(posedge mclk);
        check("wake hold", 1, 32'(coreHold));
        waitRun();
        check("wake xtal", 1, 32'(held >= XCYC - 2 * HALF));
        pwrEn <= 1'b1;
        fork
            startUp(3'h3);
            begin
                repeat (310) @(posedge mclk);
                pwrDone <= 1'b1;
            end
        join
        check("pwr xtal", 1, 32'(held >= 300 + XCYC - 2 * HALF));
        $display("test start-up sequences done");
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        testModes();
        testSelectFail();
        testStartSeq();
        summarize();
    end
endmodule
